// ### pkg/tsf_pkg.sv
`default_nettype none

package tsf_pkg;

    // ------------------------------------------------------------
    // bus shape
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tsf_bus_req_t;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_OFF_HI = 16'hFE16;
    localparam logic [ADDR_W-1:0] OFS_OFF_LO = 16'hFE17;
    localparam logic [ADDR_W-1:0] OFS_GAIN   = 16'hFE18;
    localparam logic [ADDR_W-1:0] OFS_LIMIT  = 16'hFE19;
    localparam logic [ADDR_W-1:0] OFS_STS    = 16'hFE20;
    localparam logic [ADDR_W-1:0] OFS_CLR    = 16'hFE21;
    localparam logic [ADDR_W-1:0] OFS_IEN    = 16'hFE22;
    localparam logic [ADDR_W-1:0] OFS_STATE  = 16'hFE23;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned OFF_MSB_BIT   = 0;
    localparam int unsigned OFF_SIGN_BIT  = 1;
    localparam int unsigned GAIN_SIGN_BIT = 7;
    localparam int unsigned GAIN_MAG_W    = 7;
    localparam int unsigned OFF_MAG_W     = 9;
    localparam int unsigned CMP_W         = 9;

    // event bits, shared by status, clear and enable
    localparam int unsigned EV_FAULT_SET = 0;
    localparam int unsigned EV_FAULT_CLR = 1;
    localparam int unsigned EV_LOCK_REJ  = 2;
    localparam int unsigned EV_LIMIT_BAD = 3;
    localparam int unsigned EV_N         = 4;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] TRIM_RST  = 8'h00;
    localparam logic [DATA_W-1:0] LIMIT_RST = 8'h03;
    localparam logic [EV_N-1:0]   EV_RST    = 4'h0;

    // ------------------------------------------------------------
    // threshold scale and allowed codes
    // ------------------------------------------------------------
    localparam int unsigned LIMIT_STEP_UV = 3125;
    localparam int unsigned LIMIT_FULL_UV = 800_000;
    localparam logic [DATA_W-1:0] LIMIT_MIN = 8'h03;
    localparam logic [DATA_W-1:0] LIMIT_MAX = 8'hFA;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned DEBOUNCE_MS  = 100;
    localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;

endpackage

`default_nettype wire

// ### rtl/tsf_temp_fault.sv
// Notes on behaviour
// - trim register writes are dropped unless write access is unlocked.
// - offset magnitude is 9 bits; its top bit is high register bit 0.
// - low trim register supplies the eight low offset magnitude bits.
// - high register bit 1 set subtracts the offset, clear adds it.
// - high register bits 7 to 2 are stored, readable, and unused.
// - gain register bits 6 to 0 give the gain trim magnitude.
// - gain register bit 7 set lowers the gain, clear raises it.
// - fault threshold is the limit byte with a zero bit above it.
// - only the nine top bits of the reading are compared.
// - fault raised when the compared reading is below the threshold.
// - fault flag is debounced over 100 ms.
// - one limit step is 3.125 mV, 256 codes span 0 to 800 mV.
`timescale 1ns/1ps
`default_nettype none

module tsf_temp_fault #(
    parameter int unsigned ADC_W        = 12,
    parameter int unsigned GAIN_SHIFT   = 10,
    parameter int unsigned DEBOUNCE_CYC = tsf_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_rst_b,
    // register port
    input  wire tsf_pkg::tsf_bus_req_t       i_bus,
    output logic [tsf_pkg::DATA_W-1:0]       o_rdata,
    // unlock from the protection logic
    input  wire logic                        i_trim_unlock,
    // sensor reading
    input  wire logic [ADC_W-1:0]            i_sensor_code,
    input  wire logic                        i_sensor_vld,
    // results
    output logic [ADC_W-1:0]                 o_sensor_trim,
    output logic                             o_ot_fault,
    output logic                             o_irq
);
    import tsf_pkg::*;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    // headroom so gain and offset never wrap before saturation
    localparam int unsigned SW = ADC_W + 10;
    localparam int unsigned CW = $clog2(DEBOUNCE_CYC + 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] off_hi_ff;
    logic [DATA_W-1:0] off_lo_ff;
    logic [DATA_W-1:0] gain_ff;
    logic [DATA_W-1:0] limit_ff;
    logic [EV_N-1:0]   sts_ff;
    logic [EV_N-1:0]   ien_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [ADC_W-1:0]  trim_ff;
    logic [CW-1:0]     deb_cnt_ff;
    logic              fault_ff;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire sel_hi    = (i_bus.addr == OFS_OFF_HI);
    wire sel_lo    = (i_bus.addr == OFS_OFF_LO);
    wire sel_gain  = (i_bus.addr == OFS_GAIN);
    wire sel_limit = (i_bus.addr == OFS_LIMIT);
    wire sel_sts   = (i_bus.addr == OFS_STS);
    wire sel_clr   = (i_bus.addr == OFS_CLR);
    wire sel_ien   = (i_bus.addr == OFS_IEN);
    wire sel_state = (i_bus.addr == OFS_STATE);
    wire sel_trim  = sel_hi | sel_lo | sel_gain;

    // trim writes pass only while unlocked
    wire trim_wr_ok = i_bus.wr & sel_trim & i_trim_unlock;
    wire lock_rej   = i_bus.wr & sel_trim & ~i_trim_unlock;
    wire wr_hi      = trim_wr_ok & sel_hi;
    wire wr_lo      = trim_wr_ok & sel_lo;
    wire wr_gain    = trim_wr_ok & sel_gain;
    wire wr_limit   = i_bus.wr & sel_limit;
    wire wr_ien     = i_bus.wr & sel_ien;
    wire wr_clr     = i_bus.wr & sel_clr;

    // out-of-range limit codes are stored but flagged for software
    wire limit_bad = wr_limit & ((i_bus.wdata < LIMIT_MIN) |
                                 (i_bus.wdata > LIMIT_MAX));

    // ------------------------------------------------------------
    // trim register fields
    // ------------------------------------------------------------
    wire [OFF_MAG_W-1:0]  off_mag  = {off_hi_ff[OFF_MSB_BIT], off_lo_ff};
    wire                  off_neg  = off_hi_ff[OFF_SIGN_BIT];
    wire [GAIN_MAG_W-1:0] gain_mag = gain_ff[GAIN_MAG_W-1:0];
    wire                  gain_neg = gain_ff[GAIN_SIGN_BIT];

    // ------------------------------------------------------------
    // trim arithmetic
    // ------------------------------------------------------------
    // gain trim is a fraction of the reading: code * mag / 2^GAIN_SHIFT
    logic [ADC_W+GAIN_MAG_W-1:0] gain_prod;
    logic signed [SW-1:0]        raw_s;
    logic signed [SW-1:0]        gadj_s;
    logic signed [SW-1:0]        scaled_s;
    logic signed [SW-1:0]        off_s;
    logic signed [SW-1:0]        sum_s;
    logic signed [SW-1:0]        max_s;
    logic [ADC_W-1:0]            nxt_trim_ff;

    assign gain_prod = i_sensor_code * gain_mag;
    assign raw_s     = signed'(SW'(i_sensor_code));
    assign gadj_s    = signed'(SW'(gain_prod >> GAIN_SHIFT));
    assign scaled_s  = gain_neg ? raw_s - gadj_s : raw_s + gadj_s;
    assign off_s     = signed'(SW'(off_mag));
    assign sum_s     = off_neg ? scaled_s - off_s : scaled_s + off_s;
    assign max_s     = signed'(SW'({ADC_W{1'b1}}));

    // saturate: a wrapped code would flip the fault decision
    assign nxt_trim_ff = (sum_s < 0)     ? '0 :
                         (sum_s > max_s) ? {ADC_W{1'b1}} :
                         sum_s[ADC_W-1:0];

    // ------------------------------------------------------------
    // threshold compare
    // ------------------------------------------------------------
    // one limit code is LIMIT_STEP_UV of sensor voltage on the nine-bit scale
    wire [CMP_W-1:0] cmp_code  = trim_ff[ADC_W-1 -: CMP_W];
    wire [CMP_W-1:0] cmp_thr   = {1'b0, limit_ff};
    wire             raw_fault = (cmp_code < cmp_thr);

    // ------------------------------------------------------------
    // debounce
    // ------------------------------------------------------------
    // the flag follows the compare only after it has differed for the
    // whole window; any agreement restarts the wait (both directions)
    wire differ = raw_fault ^ fault_ff;
    wire at_end = (deb_cnt_ff == CW'(DEBOUNCE_CYC - 1));
    wire flip   = differ & at_end;

    logic [CW-1:0] nxt_deb_cnt_ff;
    logic          nxt_fault_ff;
    assign nxt_deb_cnt_ff = (!differ || at_end) ? '0 : CW'(deb_cnt_ff + 1'b1);
    assign nxt_fault_ff   = flip ? raw_fault : fault_ff;

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] clr_mask;
    logic [EV_N-1:0] nxt_sts_ff;
    assign ev[EV_FAULT_SET] = flip & raw_fault;
    assign ev[EV_FAULT_CLR] = flip & ~raw_fault;
    assign ev[EV_LOCK_REJ]  = lock_rej;
    assign ev[EV_LIMIT_BAD] = limit_bad;
    assign clr_mask   = wr_clr ? i_bus.wdata[EV_N-1:0] : '0;
    // a new event wins over a clear in the same cycle
    assign nxt_sts_ff = (sts_ff & ~clr_mask) | ev;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;
    assign rd_mux = sel_hi    ? off_hi_ff :
                    sel_lo    ? off_lo_ff :
                    sel_gain  ? gain_ff :
                    sel_limit ? limit_ff :
                    sel_sts   ? DATA_W'(sts_ff) :
                    sel_ien   ? DATA_W'(ien_ff) :
                    sel_state ? DATA_W'({raw_fault, fault_ff}) :
                    '0;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // reserved high bits are plain storage and reach no arithmetic
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            off_hi_ff <= TRIM_RST;
            off_lo_ff <= TRIM_RST;
            gain_ff   <= TRIM_RST;
            limit_ff  <= LIMIT_RST;
            ien_ff    <= EV_RST;
        end else begin
            if (wr_hi)    off_hi_ff <= i_bus.wdata;
            if (wr_lo)    off_lo_ff <= i_bus.wdata;
            if (wr_gain)  gain_ff   <= i_bus.wdata;
            if (wr_limit) limit_ff  <= i_bus.wdata;
            if (wr_ien)   ien_ff    <= i_bus.wdata[EV_N-1:0];
        end
    end

    // read data for one cycle only, zero otherwise
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            rdata_ff <= '0;
            sts_ff   <= EV_RST;
        end else begin
            rdata_ff <= i_bus.rd ? rd_mux : '0;
            sts_ff   <= nxt_sts_ff;
        end
    end

    // ------------------------------------------------------------
    // datapath registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            trim_ff    <= '0;
            deb_cnt_ff <= '0;
            fault_ff   <= 1'b0;
        end else begin
            if (i_sensor_vld) trim_ff <= nxt_trim_ff;
            deb_cnt_ff <= nxt_deb_cnt_ff;
            fault_ff   <= nxt_fault_ff;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_rdata       = rdata_ff;
    assign o_sensor_trim = trim_ff;
    assign o_ot_fault    = fault_ff;
    assign o_irq         = |(sts_ff & ien_ff);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    // helper: consecutive cycles with the compare asserted, saturating
    logic [CW-1:0] run_ff;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            run_ff <= '0;
        end else begin
            run_ff <= !raw_fault ? '0 :
                      (&run_ff)  ? run_ff : CW'(run_ff + 1'b1);
        end
    end

    wire quiet_gain = (gain_mag == '0);
    wire [ADC_W:0] add_ref = {1'b0, i_sensor_code} + (ADC_W+1)'(off_mag);
    // reference difference, only looked at when it cannot go below zero
    wire [ADC_W-1:0] sub_ref = i_sensor_code - ADC_W'(off_mag);

    a_locked_trim_hold: assert property (
        (i_bus.wr && sel_trim && !i_trim_unlock)
        |=> $stable(off_hi_ff) && $stable(off_lo_ff) && $stable(gain_ff))
        else $error("trim register changed while locked");

    a_unlocked_low_write: assert property (
        (i_bus.wr && sel_lo && i_trim_unlock)
        |=> off_lo_ff == $past(i_bus.wdata))
        else $error("unlocked low trim write not stored");

    a_reserved_bits_kept: assert property (
        (i_bus.wr && sel_hi && i_trim_unlock)
        |=> off_hi_ff == $past(i_bus.wdata))
        else $error("reserved trim bits not stored");

    a_offset_adds: assert property (
        (i_sensor_vld && quiet_gain && !off_neg && !add_ref[ADC_W])
        |=> trim_ff == $past(add_ref[ADC_W-1:0]))
        else $error("positive offset not added");

    a_offset_subtracts: assert property (
        (i_sensor_vld && quiet_gain && off_neg && i_sensor_code >= ADC_W'(off_mag))
        |=> trim_ff == $past(sub_ref))
        else $error("negative nine-bit offset not subtracted");

    a_gain_lowers: assert property (
        (i_sensor_vld && gain_neg && off_mag == '0)
        |=> trim_ff <= $past(i_sensor_code))
        else $error("negative gain raised the reading");

    a_gain_raises: assert property (
        (i_sensor_vld && !gain_neg && off_mag == '0)
        |=> trim_ff >= $past(i_sensor_code))
        else $error("positive gain lowered the reading");

    a_thresh_top_zero: assert property (
        raw_fault |-> !trim_ff[ADC_W-1])
        else $error("compare fired with reading top bit set");

    a_fault_compare: assert property (
        (limit_ff[7] && trim_ff[ADC_W-1 -: 2] == 2'b00) |-> raw_fault)
        else $error("low reading missed the top limit");

    a_fault_debounced: assert property (
        $rose(fault_ff) |-> $past(run_ff) >= CW'(DEBOUNCE_CYC - 1))
        else $error("fault set before the debounce window");

    a_fault_needs_low: assert property (
        $rose(fault_ff) |-> $past(raw_fault))
        else $error("fault set without a low reading");

    a_event_beats_clear: assert property (
        (wr_clr && |(ev & clr_mask)) |=> ((sts_ff & $past(ev)) == $past(ev)))
        else $error("clear beat a same-cycle event");

    a_read_one_cycle: assert property (
        !i_bus.rd |=> o_rdata == '0)
        else $error("read data outside its cycle");

    c_fault_raised: cover property ($rose(fault_ff));
    c_fault_cleared: cover property ($fell(fault_ff));
    c_locked_reject: cover property (lock_rej);
    c_negative_trim: cover property (i_sensor_vld && off_neg && gain_neg);

endmodule

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import tsf_pkg::*;

    // ------------------------------------------------------------
    // bench signals
    // ------------------------------------------------------------
    localparam int unsigned DEB = 8;  // short debounce so the run stays brief
    logic              i_ref_clk;
    logic              i_rst_b;
    tsf_bus_req_t      bus;
    logic [7:0]        o_rdata;
    logic              unlock;
    logic [11:0]       code;
    logic              vld;
    logic [11:0]       o_sensor_trim;
    logic              o_ot_fault;
    logic              o_irq;
    int                bad_count;
    int                n_tests;

    tsf_temp_fault #(.ADC_W(12), .GAIN_SHIFT(10), .DEBOUNCE_CYC(DEB)) i_tsf_temp_fault (
        .i_ref_clk     (i_ref_clk),
        .i_rst_b       (i_rst_b),
        .i_bus         (bus),
        .o_rdata       (o_rdata),
        .i_trim_unlock (unlock),
        .i_sensor_code (code),
        .i_sensor_vld  (vld),
        .o_sensor_trim (o_sensor_trim),
        .o_ot_fault    (o_ot_fault),
        .o_irq         (o_irq)
    );

    // ------------------------------------------------------------
    // clock and shared tasks
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    task automatic stop_test();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one idle cycle follows every strobe, so no task re-enters on the same edge
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= d;
        @(posedge i_ref_clk);
        bus.wr    <= 1'b0;
    endtask

    task automatic rd_mask(input logic [15:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge i_ref_clk);
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge i_ref_clk);
        bus.rd   <= 1'b0;
        #1;
        check({8'h00, o_rdata & m}, {8'h00, exp});
    endtask

    task automatic capture(input logic [11:0] c);
        @(posedge i_ref_clk);
        code <= c;
        vld  <= 1'b1;
        @(posedge i_ref_clk);
        vld  <= 1'b0;
        #1;
    endtask

    // bounded wait for the debounced flag; running out ends the run
    task automatic wait_fault(input logic exp, input int lim);
        int n;
        n = 0;
        while (o_ot_fault !== exp && n < lim) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        check({15'h0000, o_ot_fault}, {15'h0000, exp});
        if (o_ot_fault !== exp) stop_test();
    endtask

    // reference trim arithmetic, saturated to the code range
    function automatic logic [11:0] model(input logic [7:0] hi, input logic [7:0] lo,
                                          input logic [7:0] gn, input logic [11:0] c);
        int g;
        int s;
        int t;
        g = (int'(c) * int'(gn[6:0])) >>> 10;
        s = gn[7] ? int'(c) - g : int'(c) + g;
        t = hi[1] ? s - int'({hi[0], lo}) : s + int'({hi[0], lo});
        if (t < 0) t = 0;
        if (t > 4095) t = 4095;
        return t[11:0];
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        #1;
        check({2'b00, o_irq, o_ot_fault, o_sensor_trim}, 16'h0000);
        check({8'h00, o_rdata}, 16'h0000);
        // the trim resets to zero, below the reset limit; a high reading keeps the compare quiet
        capture(12'hfff);
        rd_mask(OFS_OFF_HI, 8'hff, 8'h00);
        rd_mask(OFS_OFF_LO, 8'hff, 8'h00);
        rd_mask(OFS_GAIN, 8'hff, 8'h00);
        rd_mask(OFS_LIMIT, 8'hff, 8'h03);
        rd_mask(OFS_STS, 8'hff, 8'h00);
        rd_mask(OFS_IEN, 8'hff, 8'h00);
        rd_mask(16'h0040, 8'hff, 8'h00);  // unmapped place reads zero
    endtask

    task automatic t_lock();
        unlock <= 1'b0;
        wr_reg(OFS_OFF_HI, 8'hff);
        wr_reg(OFS_OFF_LO, 8'haa);
        wr_reg(OFS_GAIN, 8'h55);
        rd_mask(OFS_OFF_HI, 8'hff, 8'h00);
        rd_mask(OFS_OFF_LO, 8'hff, 8'h00);
        rd_mask(OFS_GAIN, 8'hff, 8'h00);
        rd_mask(OFS_STS, 8'h04, 8'h04);
        wr_reg(OFS_STS, 8'h00);  // status is read-only, write must not clear it
        #1;
        check({15'h0000, o_irq}, 16'h0000);
        wr_reg(OFS_IEN, 8'h04);
        #1;
        check({15'h0000, o_irq}, 16'h0001);
        wr_reg(OFS_CLR, 8'h04);
        #1;
        check({15'h0000, o_irq}, 16'h0000);
        rd_mask(OFS_STS, 8'hff, 8'h00);
    endtask

    task automatic t_limits();
        logic [7:0] codes [4] = '{8'h02, 8'h03, 8'hfa, 8'hfb};
        logic [7:0] flag  [4] = '{8'h08, 8'h00, 8'h00, 8'h08};
        for (int k = 0; k < 4; k++) begin
            wr_reg(OFS_LIMIT, codes[k]);
            rd_mask(OFS_LIMIT, 8'hff, codes[k]);
            rd_mask(OFS_STS, 8'h08, flag[k]);
            wr_reg(OFS_CLR, 8'h08);
        end
    endtask

    task automatic t_fault();
        logic stayed;
        wr_reg(OFS_IEN, 8'h03);
        wr_reg(OFS_LIMIT, 8'h40);
        capture(12'h200);
        rd_mask(OFS_STATE, 8'h02, 8'h00);
        capture(12'h1ff);
        repeat (5) @(posedge i_ref_clk);
        #1;
        check({15'h0000, o_ot_fault}, 16'h0000);
        wait_fault(1'b1, 8);
        rd_mask(OFS_STS, 8'h01, 8'h01);
        check({15'h0000, o_irq}, 16'h0001);
        wr_reg(OFS_CLR, 8'h01);
        capture(12'hfff);
        wait_fault(1'b0, 16);
        rd_mask(OFS_STS, 8'h03, 8'h02);
        wr_reg(OFS_CLR, 8'h03);
        // a short dip below the limit must not reach the flag
        capture(12'h100);
        repeat (2) @(posedge i_ref_clk);
        capture(12'hfff);
        stayed = 1'b1;
        repeat (12) begin
            @(posedge i_ref_clk);
            #1;
            if (o_ot_fault !== 1'b0) stayed = 1'b0;
        end
        check({15'h0000, stayed}, 16'h0001);
        // threshold top bit is zero, so top nine bits of 0x800, 0x100, are above 0x0fa
        wr_reg(OFS_LIMIT, 8'hfa);
        capture(12'h800);
        rd_mask(OFS_STATE, 8'h02, 8'h00);
        capture(12'h7cf);
        rd_mask(OFS_STATE, 8'h02, 8'h02);
        capture(12'hfff);
        wait_fault(1'b0, 16);
        check({15'h0000, o_irq}, 16'h0000);
    endtask

    task automatic t_math();
        logic [7:0]  hi [7] = '{8'h01, 8'h02, 8'hfc, 8'h00, 8'h00, 8'h03, 8'h01};
        logic [7:0]  lo [7] = '{8'h23, 8'h10, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
        logic [7:0]  gn [7] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'hc0, 8'h00, 8'h00};
        logic [11:0] cd [7] = '{12'h400, 12'h400, 12'h400, 12'h800, 12'h800, 12'h010, 12'hff0};
        unlock <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            wr_reg(OFS_OFF_HI, hi[k]);
            wr_reg(OFS_OFF_LO, lo[k]);
            wr_reg(OFS_GAIN, gn[k]);
            rd_mask(OFS_OFF_HI, 8'hff, hi[k]);
            rd_mask(OFS_GAIN, 8'hff, gn[k]);
            capture(cd[k]);
            check({4'h0, o_sensor_trim}, {4'h0, model(hi[k], lo[k], gn[k], cd[k])});
        end
        // compare must see the trimmed reading, not the raw one
        wr_reg(OFS_LIMIT, 8'h40);
        wr_reg(OFS_GAIN, 8'h00);
        wr_reg(OFS_OFF_HI, 8'h00);
        wr_reg(OFS_OFF_LO, 8'h20);
        capture(12'h1f0);
        rd_mask(OFS_STATE, 8'h02, 8'h00);
        wr_reg(OFS_OFF_HI, 8'h02);
        capture(12'h210);
        rd_mask(OFS_STATE, 8'h02, 8'h02);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        bad_count = 0;
        n_tests   = 0;
        i_rst_b   = 1'b0;
        bus       = '0;
        unlock    = 1'b0;
        code      = 12'hfff;
        vld       = 1'b0;
        repeat (16) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        t_reset();
        t_lock();
        t_limits();
        t_fault();
        t_math();
        stop_test();
    end

endmodule

`default_nettype wire
